// [logic/pfp_params.svh]
`ifndef PFP_PARAMS_SVH
`define PFP_PARAMS_SVH
// register byte offsets
`define PFP_OFS_CTRL     10'h000
`define PFP_OFS_STATUS   10'h004
`define PFP_OFS_CNT_CLR  10'h008
`define PFP_OFS_REM_ALM  10'h00c
`define PFP_OFS_REM_TRP  10'h010
`define PFP_OFS_RAT_ALM  10'h014
`define PFP_OFS_RAT_TRP  10'h018
`define PFP_OFS_EXP_TIM  10'h01c
`define PFP_OFS_PRE_PF   10'h020
`define PFP_OFS_REC_IDX  10'h024
`define PFP_OFS_REC_TIM  10'h028
`define PFP_OFS_REC_INF  10'h02c
`define PFP_OFS_CNT0     10'h040
`define PFP_OFS_GRP      2'h1
// control field positions
`define PFP_CTRL_MODE_LSB  0
`define PFP_CTRL_FEN_BIT   3
`define PFP_CTRL_FST_LSB   4
`define PFP_CTRL_SRC_LSB   8
// reset values
`define PFP_RST_TRIP_LVL   7'h50
`define PFP_RST_ALM_LVL    7'h5a
`define PFP_RST_AMODE      1'h1
`define PFP_RST_DLY        19'h00000
`define PFP_LVL_MIN        7'h05
`define PFP_LVL_MAX        7'h63
// reset ratio in tenths of a percent
`define PFP_RESET_RATIO    20'h00406
// timing in its own unit
`define PFP_CLK_NS         100
`define PFP_CYCLE_NS       5000000
`define PFP_MS_NS          1000000
`define PFP_NREC           12
`define PFP_NAVG           4
`endif

// [logic/pfp_pkg.sv]
package pfp_pkg;
  typedef enum logic [2:0] {
    NODE_ON      = 3'h1,
    NODE_BLK     = 3'h2,
    NODE_TEST    = 3'h3,
    NODE_TESTBLK = 3'h4,
    NODE_OFF     = 3'h5
  } pfp_node_t;
  typedef enum logic [2:0] {
    COND_NORMAL  = 3'h0,
    COND_START   = 3'h1,
    COND_TRIP    = 3'h2,
    COND_BLOCKED = 3'h3,
    COND_ASTART  = 3'h4,
    COND_ALARM   = 3'h5
  } pfp_cond_t;
  typedef enum logic [1:0] {
    SRC_A = 2'h1,
    SRC_B = 2'h2
  } pfp_src_t;
  // output signal index used by events and counters
  typedef enum logic [2:0] {
    SIG_ASTART = 3'h0,
    SIG_ALARM  = 3'h1,
    SIG_START  = 3'h2,
    SIG_TRIP   = 3'h3,
    SIG_BLOCK  = 3'h4
  } pfp_sig_t;
endpackage

// [logic/pfp_stage.sv]
`timescale 1ns/1ns
`include "pfp_params.svh"
// Function
// - eight setting groups, chosen by common selector
// - five outputs, ON/OFF events on each change
// - instant mode gives start and trip together
// - event time stamps in milliseconds
// - clearable counter per output event
// - power factor taken once per 5 ms
// - keep 20 ms averaged pre-fault power factor
// - node mode codes 1..5, On after reset
// - forcing overrides condition, codes 0..5
// - source select module a or b
// - general settings ignore group changes
// - pick-up below level, release above 103 %
// - mode 0 trip only, 1 trip and alarm
// - trip level 0.05..0.99, default 0.8
// - alarm level 0.05..0.99, default 0.9
// - start rises only when not blocked
// - condition indication codes 0..5
// - remaining time to alarm, 5 ms steps
// - signed remaining time to trip
// - ratio of measurement to alarm level
// - ratio to trip level, expected operating time
// - blocking sampled per cycle, gives blocked
// - definite delays on trip and reset
// - twelve records of start/trip/blocked ON
module pfp_stage #(
  parameter int CYCLE_CLKS = `PFP_CYCLE_NS / `PFP_CLK_NS,
  parameter int MS_CLKS    = `PFP_MS_NS / `PFP_CLK_NS
) (
  input  wire logic        REF_CLK,
  input  wire logic        RESETN,
  input  wire logic [2:0]  GROUP_SEL,
  input  wire logic [9:0]  PF_A,
  input  wire logic [9:0]  PF_B,
  input  wire logic        BLOCK_IN,
  input  wire logic [9:0]  REG_ADDR,
  input  wire logic [31:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [31:0] REG_RDATA,
  output logic             ALARM_START,
  output logic             ALARM,
  output logic             START,
  output logic             TRIP,
  output logic             BLOCKED,
  output logic             EVT_VALID,
  output logic      [2:0]  EVT_SIG,
  output logic             EVT_ON,
  output logic      [31:0] EVT_TIME
);
  // general settings
  pfp_pkg::pfp_node_t node_q;
  logic               fen_q;
  pfp_pkg::pfp_cond_t fst_q;
  pfp_pkg::pfp_src_t  src_q;
  // per-group settings
  logic [6:0]  trip_lvl_q [8];
  logic [6:0]  alm_lvl_q  [8];
  logic        amode_q    [8];
  logic [18:0] trip_dly_q [8];
  logic [18:0] alm_dly_q  [8];
  logic [18:0] rst_dly_q  [8];
  // timebase
  logic [31:0] cyc_cnt_q;
  logic [31:0] ms_cnt_q;
  logic [31:0] ms_time_q;
  logic        tick;
  // protection state
  logic        trip_pu_q, alm_pu_q;
  logic [18:0] tcnt_q, acnt_q, rcnt_q;
  logic [4:0]  out_q;
  logic [4:0]  ev_pend_q, ev_val_q;
  logic [31:0] ev_time_q;
  logic [15:0] cnt_q [5];
  logic [4:0]  cnt_clr;
  logic [9:0]  hist_q [`PFP_NAVG];
  logic [9:0]  pre_pf_q;
  logic [19:0] rem_alm_q, rem_trp_q;
  logic [16:0] rat_alm_q, rat_trp_q;
  logic [3:0]  rec_idx_q, rec_wp_q;
  logic [31:0] rec_tim_q [`PFP_NREC];
  logic [15:0] rec_inf_q [`PFP_NREC];
  logic [3:0]  rec_rd_q;

  // live quantities for the current cycle
  logic [9:0]  pf;
  logic [6:0]  tl, al;
  logic        amode, en, bmode, blk;
  logic        trip_pu_d, alm_pu_d, trip_ok, alm_ok;
  logic [18:0] tdly, adly, rdly;
  logic        start_d, trip_d, as_d, alarm_d, blocked_d;
  logic [4:0]  out_d;
  logic [11:0] avg_sum;
  logic [2:0]  g;
  logic        wr_grp;

  assign tick   = (cyc_cnt_q == 32'(CYCLE_CLKS - 1));
  assign g      = GROUP_SEL;
  assign wr_grp = REG_WR & (REG_ADDR[9:8] == `PFP_OFS_GRP);
  assign cnt_clr = (REG_WR && REG_ADDR == `PFP_OFS_CNT_CLR) ? REG_WDATA[4:0] : 5'h00;

  // 5 ms processing cycle and 1 ms time stamp base
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      cyc_cnt_q <= 32'h0;
      ms_cnt_q  <= 32'h0;
      ms_time_q <= 32'h0;
    end else begin
      cyc_cnt_q <= tick ? 32'h0 : cyc_cnt_q + 32'h1;
      if (ms_cnt_q == 32'(MS_CLKS - 1)) begin
        ms_cnt_q  <= 32'h0;
        ms_time_q <= ms_time_q + 32'h1;
      end else begin
        ms_cnt_q <= ms_cnt_q + 32'h1;
      end
    end
  end

  // general settings; untouched by group selection
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      node_q <= pfp_pkg::NODE_ON;
      fen_q  <= 1'b0;
      fst_q  <= pfp_pkg::COND_NORMAL;
      src_q  <= pfp_pkg::SRC_A;
    end else if (REG_WR && REG_ADDR == `PFP_OFS_CTRL) begin
      if (REG_WDATA[2:0] >= 3'h1 && REG_WDATA[2:0] <= 3'h5)
        node_q <= pfp_pkg::pfp_node_t'(REG_WDATA[2:0]);
      fen_q <= REG_WDATA[`PFP_CTRL_FEN_BIT];
      if (REG_WDATA[6:4] <= 3'h5)
        fst_q <= pfp_pkg::pfp_cond_t'(REG_WDATA[6:4]);
      if (REG_WDATA[9:8] == 2'h1 || REG_WDATA[9:8] == 2'h2)
        src_q <= pfp_pkg::pfp_src_t'(REG_WDATA[9:8]);
    end
  end

  // eight setting groups; levels clamped into the settable range
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_grp
      always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
          trip_lvl_q[gi] <= `PFP_RST_TRIP_LVL;
          alm_lvl_q[gi]  <= `PFP_RST_ALM_LVL;
          amode_q[gi]    <= `PFP_RST_AMODE;
          trip_dly_q[gi] <= `PFP_RST_DLY;
          alm_dly_q[gi]  <= `PFP_RST_DLY;
          rst_dly_q[gi]  <= `PFP_RST_DLY;
        end else if (wr_grp && REG_ADDR[6:4] == 3'(gi)) begin
          unique case (REG_ADDR[3:2])
            2'h0: begin
              trip_lvl_q[gi] <= (REG_WDATA[6:0] < `PFP_LVL_MIN) ? `PFP_LVL_MIN :
                                (REG_WDATA[6:0] > `PFP_LVL_MAX) ? `PFP_LVL_MAX : REG_WDATA[6:0];
              alm_lvl_q[gi]  <= (REG_WDATA[14:8] < `PFP_LVL_MIN) ? `PFP_LVL_MIN :
                                (REG_WDATA[14:8] > `PFP_LVL_MAX) ? `PFP_LVL_MAX : REG_WDATA[14:8];
              amode_q[gi]    <= REG_WDATA[16];
            end
            2'h1: trip_dly_q[gi] <= REG_WDATA[18:0];
            2'h2: alm_dly_q[gi]  <= REG_WDATA[18:0];
            2'h3: rst_dly_q[gi]  <= REG_WDATA[18:0];
          endcase
        end
      end
    end
  endgenerate

  // pick-up comparison with built-in reset ratio, blocking and delays
  always_comb begin
    pf    = (src_q == pfp_pkg::SRC_B) ? PF_B : PF_A;
    tl    = trip_lvl_q[g];
    al    = alm_lvl_q[g];
    amode = amode_q[g];
    tdly  = trip_dly_q[g];
    adly  = alm_dly_q[g];
    rdly  = rst_dly_q[g];
    en    = (node_q == pfp_pkg::NODE_ON) || (node_q == pfp_pkg::NODE_TEST);
    bmode = (node_q == pfp_pkg::NODE_BLK) || (node_q == pfp_pkg::NODE_TESTBLK);
    blk   = BLOCK_IN | bmode;
    // pf in thousandths, levels in hundredths
    trip_pu_d = trip_pu_q ? (20'(pf) * 20'd100 <= 20'(tl) * `PFP_RESET_RATIO)
                          : (20'(pf) < 20'(tl) * 20'd10);
    alm_pu_d  = alm_pu_q ? (20'(pf) * 20'd100 <= 20'(al) * `PFP_RESET_RATIO)
                         : (20'(pf) < 20'(al) * 20'd10);
    trip_pu_d = trip_pu_d & (en | bmode);
    alm_pu_d  = alm_pu_d & amode & (en | bmode);
    trip_ok   = trip_pu_d & ~blk & en;
    alm_ok    = alm_pu_d & ~blk & en;
    // start holds through the reset delay after pick-up goes away
    start_d   = trip_ok | (out_q[pfp_pkg::SIG_START] & (rcnt_q < rdly));
    trip_d    = trip_ok & (tcnt_q >= tdly);
    as_d      = alm_ok;
    alarm_d   = alm_ok & (acnt_q >= adly);
    blocked_d = (blk & (trip_pu_d | alm_pu_d)) | bmode;
    out_d     = {blocked_d, trip_d, start_d, alarm_d, as_d};
    if (node_q == pfp_pkg::NODE_OFF)
      out_d = 5'h00;
    if (fen_q) begin
      unique case (fst_q)
        pfp_pkg::COND_START:   out_d = 5'h04;
        pfp_pkg::COND_TRIP:    out_d = 5'h0c;
        pfp_pkg::COND_BLOCKED: out_d = 5'h10;
        pfp_pkg::COND_ASTART:  out_d = 5'h01;
        pfp_pkg::COND_ALARM:   out_d = 5'h03;
        default:               out_d = 5'h00;
      endcase
    end
  end

  // pick-up memory and definite time counters, advanced once per cycle
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      trip_pu_q <= 1'b0;
      alm_pu_q  <= 1'b0;
      tcnt_q    <= 19'h0;
      acnt_q    <= 19'h0;
      rcnt_q    <= 19'h0;
      out_q     <= 5'h00;
    end else if (tick) begin
      trip_pu_q <= trip_pu_d;
      alm_pu_q  <= alm_pu_d;
      tcnt_q    <= trip_ok ? ((tcnt_q == '1) ? tcnt_q : tcnt_q + 19'h1) : 19'h0;
      acnt_q    <= alm_ok ? ((acnt_q == '1) ? acnt_q : acnt_q + 19'h1) : 19'h0;
      rcnt_q    <= (trip_ok || !out_q[pfp_pkg::SIG_START]) ? 19'h0 : rcnt_q + 19'h1;
      out_q     <= out_d;
    end
  end

  assign avg_sum = 12'(hist_q[0]) + 12'(hist_q[1]) + 12'(hist_q[2]) + 12'(hist_q[3]);

  // info values: remaining times, ratios, pre-fault average
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      for (int i = 0; i < `PFP_NAVG; i++)
        hist_q[i] <= 10'h0;
      pre_pf_q  <= 10'h0;
      rem_alm_q <= 20'h0;
      rem_trp_q <= 20'h0;
      rat_alm_q <= 17'h0;
      rat_trp_q <= 17'h0;
    end else if (tick) begin
      hist_q[0] <= pf;
      for (int i = 1; i < `PFP_NAVG; i++)
        hist_q[i] <= hist_q[i-1];
      // average of the four cycles before this one
      pre_pf_q  <= avg_sum[11:2];
      // time to alarm never goes below zero; only the trip side is signed
      rem_alm_q <= (alm_ok && acnt_q < adly) ? 20'(adly) - 20'(acnt_q) : 20'h0;
      rem_trp_q <= trip_ok ? 20'(tdly) - 20'(tcnt_q) : 20'h0;
      // divider only settles once per cycle; levels are never zero
      rat_alm_q <= 17'((20'(pf) * 20'd10) / 20'(al));
      rat_trp_q <= 17'((20'(pf) * 20'd10) / 20'(tl));
    end
  end

  // event queue: changes caught at a tick share one stamp, sent one per clock
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ev_pend_q <= 5'h00;
      ev_val_q  <= 5'h00;
      ev_time_q <= 32'h0;
      EVT_VALID <= 1'b0;
      EVT_SIG   <= 3'h0;
      EVT_ON    <= 1'b0;
      EVT_TIME  <= 32'h0;
    end else begin
      EVT_VALID <= 1'b0;
      if (tick) begin
        ev_pend_q <= out_d ^ out_q;
        ev_val_q  <= out_d;
        ev_time_q <= ms_time_q;
      end else if (ev_pend_q != 5'h00) begin
        for (int i = 4; i >= 0; i--) begin
          if (ev_pend_q[i]) begin
            EVT_SIG <= 3'(i);
            EVT_ON  <= ev_val_q[i];
          end
        end
        EVT_VALID <= 1'b1;
        EVT_TIME  <= ev_time_q;
        ev_pend_q <= ev_pend_q & (ev_pend_q - 5'h01);
      end
    end
  end

  // cumulative ON counters; a count in the clearing cycle survives as one
  generate
    for (gi = 0; gi < 5; gi++) begin : g_cnt
      always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN)
          cnt_q[gi] <= 16'h0;
        else if (tick && out_d[gi] && !out_q[gi])
          cnt_q[gi] <= cnt_clr[gi] ? 16'h1 : cnt_q[gi] + 16'h1;
        else if (cnt_clr[gi])
          cnt_q[gi] <= 16'h0;
      end
    end
  endgenerate

  // twelve-deep ring of ON records for start, trip and blocked
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rec_wp_q <= 4'h0;
      for (int i = 0; i < `PFP_NREC; i++) begin
        rec_tim_q[i] <= 32'h0;
        rec_inf_q[i] <= 16'h0;
      end
    end else if (tick && (out_d[4:2] & ~out_q[4:2]) != 3'h0) begin
      rec_tim_q[rec_wp_q] <= ms_time_q;
      rec_inf_q[rec_wp_q] <= {g, (out_d[3] & !out_q[3]) ? pfp_pkg::SIG_TRIP :
                              (out_d[2] & !out_q[2]) ? pfp_pkg::SIG_START : pfp_pkg::SIG_BLOCK,
                              avg_sum[11:2]};
      rec_wp_q <= (rec_wp_q == 4'(`PFP_NREC - 1)) ? 4'h0 : rec_wp_q + 4'h1;
    end
  end

  // output flops and record index register
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      {BLOCKED, TRIP, START, ALARM, ALARM_START} <= 5'h00;
      rec_idx_q <= 4'h0;
    end else begin
      {BLOCKED, TRIP, START, ALARM, ALARM_START} <= (tick) ? out_d : out_q;
      if (REG_WR && REG_ADDR == `PFP_OFS_REC_IDX && REG_WDATA[3:0] < 4'(`PFP_NREC))
        rec_idx_q <= REG_WDATA[3:0];
    end
  end

  assign rec_rd_q = rec_idx_q;

  // read port; data stand in the cycle after the strobe only
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      REG_RDATA <= 32'h0;
    end else if (!REG_RD) begin
      REG_RDATA <= 32'h0;
    end else if (REG_ADDR[9:8] == `PFP_OFS_GRP) begin
      unique case (REG_ADDR[3:2])
        2'h0: REG_RDATA <= {15'h0, amode_q[REG_ADDR[6:4]], 1'b0, alm_lvl_q[REG_ADDR[6:4]],
                            1'b0, trip_lvl_q[REG_ADDR[6:4]]};
        2'h1: REG_RDATA <= {13'h0, trip_dly_q[REG_ADDR[6:4]]};
        2'h2: REG_RDATA <= {13'h0, alm_dly_q[REG_ADDR[6:4]]};
        2'h3: REG_RDATA <= {13'h0, rst_dly_q[REG_ADDR[6:4]]};
      endcase
    end else begin
      REG_RDATA <= 32'h0;
      case (REG_ADDR)
        `PFP_OFS_CTRL:    REG_RDATA <= {22'h0, src_q, 1'b0, fst_q, fen_q, node_q};
        `PFP_OFS_STATUS:  REG_RDATA <= {19'h0, out_q, 5'h0,
                                        out_q[3] ? pfp_pkg::COND_TRIP :
                                        out_q[1] ? pfp_pkg::COND_ALARM :
                                        out_q[2] ? pfp_pkg::COND_START :
                                        out_q[0] ? pfp_pkg::COND_ASTART :
                                        out_q[4] ? pfp_pkg::COND_BLOCKED : pfp_pkg::COND_NORMAL};
        `PFP_OFS_REM_ALM: REG_RDATA <= {12'h0, rem_alm_q};
        `PFP_OFS_REM_TRP: REG_RDATA <= {{12{rem_trp_q[19]}}, rem_trp_q};
        `PFP_OFS_RAT_ALM: REG_RDATA <= {15'h0, rat_alm_q};
        `PFP_OFS_RAT_TRP: REG_RDATA <= {15'h0, rat_trp_q};
        `PFP_OFS_EXP_TIM: REG_RDATA <= {13'h0, tdly};
        `PFP_OFS_PRE_PF:  REG_RDATA <= {22'h0, pre_pf_q};
        `PFP_OFS_REC_IDX: REG_RDATA <= {24'h0, rec_wp_q, rec_idx_q};
        `PFP_OFS_REC_TIM: REG_RDATA <= rec_tim_q[rec_rd_q];
        `PFP_OFS_REC_INF: REG_RDATA <= {16'h0, rec_inf_q[rec_rd_q]};
        default: begin
          for (int i = 0; i < 5; i++)
            if (REG_ADDR == `PFP_OFS_CNT0 + 10'(4 * i))
              REG_RDATA <= {16'h0, cnt_q[i]};
        end
      endcase
    end
  end

endmodule // pfp_stage

// [tb/pfp_stage_asserts.sv]
`timescale 1ns/1ns
module pfp_stage_asserts #(
  parameter int CYCLE_CLKS = 20
) (
  input wire logic        REF_CLK,
  input wire logic        RESETN,
  input wire logic        REG_RD,
  input wire logic [31:0] REG_RDATA,
  input wire logic        ALARM_START,
  input wire logic        ALARM,
  input wire logic        START,
  input wire logic        TRIP,
  input wire logic        BLOCKED,
  input wire logic        EVT_VALID,
  input wire logic [2:0]  EVT_SIG,
  input wire logic        EVT_ON,
  input wire logic [31:0] EVT_TIME
);
  logic [15:0] cyc_q;
  logic [4:0]  outs;
  // outputs in signal index order, so an event can be matched to its level
  assign outs = {BLOCKED, TRIP, START, ALARM, ALARM_START};
  // phase in the 5 ms cycle, restarted by reset just like the stage's own
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) cyc_q <= 16'h0000;
    else cyc_q <= (cyc_q == 16'(CYCLE_CLKS - 1)) ? 16'h0000 : cyc_q + 16'h0001;
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);
  chk_rdata_slot: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0)
    else $error("read data outside its slot");
  chk_outs_on_tick: assert property (cyc_q > 16'h0001 |-> $stable(outs))
    else $error("output changed away from a tick");
  chk_start_blk_excl: assert property (!(START && BLOCKED))
    else $error("start and blocked together");
  chk_evt_sig_range: assert property (EVT_VALID |-> EVT_SIG <= 3'h4)
    else $error("event index out of range");
  chk_evt_window: assert property (EVT_VALID |-> cyc_q < 16'h0008)
    else $error("event far from its tick");
  chk_evt_level: assert property (EVT_VALID && EVT_SIG <= 3'h4 |-> EVT_ON == outs[EVT_SIG])
    else $error("event edge disagrees with output");
  chk_evt_time_same: assert property (EVT_VALID && $past(EVT_VALID) |-> $stable(EVT_TIME))
    else $error("events of one tick differ in time");
  chk_evt_order: assert property (EVT_VALID && $past(EVT_VALID) |-> EVT_SIG > $past(EVT_SIG))
    else $error("events out of index order");
  chk_start_on_evt: assert property ($rose(START) |-> ##[1:6] (EVT_VALID && EVT_ON && EVT_SIG == 3'h2))
    else $error("no event for start rising");
  chk_trip_off_evt: assert property ($fell(TRIP) |-> ##[1:6] (EVT_VALID && !EVT_ON && EVT_SIG == 3'h3))
    else $error("no event for trip falling");
  cov_start_trip: cover property ($rose(START) && $rose(TRIP));
  cov_blocked: cover property ($rose(BLOCKED));
  cov_alarm: cover property ($rose(ALARM));
  cov_evt_off: cover property (EVT_VALID && !EVT_ON);
endmodule // pfp_stage_asserts

bind pfp_stage pfp_stage_asserts #(.CYCLE_CLKS(CYCLE_CLKS)) u_chk (
  .REF_CLK(REF_CLK), .RESETN(RESETN), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .ALARM_START(ALARM_START), .ALARM(ALARM), .START(START), .TRIP(TRIP), .BLOCKED(BLOCKED),
  .EVT_VALID(EVT_VALID), .EVT_SIG(EVT_SIG), .EVT_ON(EVT_ON), .EVT_TIME(EVT_TIME));

// [tb/pfp_meas_model.sv]
`timescale 1ns/1ns
module pfp_meas_model #(
  parameter int CYCLE_CLKS = 20
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [9:0] pf_a_req,
  input  wire logic [9:0] pf_b_req,
  input  wire logic       blk_req,
  output logic      [9:0] pf_a,
  output logic      [9:0] pf_b,
  output logic            blk
);
  int cyc;
  // meters publish once a cycle, half a cycle clear of the stage's sampling edge
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc <= 0;
      pf_a <= 10'h3e8;
      pf_b <= 10'h3e8;
      blk <= 1'b0;
    end else begin
      cyc <= (cyc == CYCLE_CLKS - 1) ? 0 : cyc + 1;
      if (cyc == CYCLE_CLKS / 2) begin
        pf_a <= pf_a_req;
        pf_b <= pf_b_req;
        blk <= blk_req; // a block lands with the readings, half a cycle before the tick
      end
    end
  end
endmodule // pfp_meas_model

// [tb/pfp_stage_tb_top.sv]
`timescale 1ns/1ns
module pfp_stage_tb_top;
  localparam int CYC = 20;
  localparam int MSC = 4;
  localparam logic [4:0] FRC [6] = '{5'h00, 5'h04, 5'h0c, 5'h10, 5'h01, 5'h03};
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [2:0]  grp = 3'h0;
  logic [9:0]  ra = 10'h3e8;
  logic [9:0]  rb = 10'h3e8;
  logic        rblk = 1'b0;
  logic [9:0]  addr = 10'h000;
  logic [31:0] wd = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [9:0]  pfa, pfb;
  logic        blk, o_ast, o_alm, o_st, o_tr, o_bl, ev, eon;
  logic [2:0]  esig;
  logic [31:0] rdata, etime;
  logic [4:0]  mo = 5'h00;
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          seed = 83493;
  int          cyc = 0;
  int          node = 1, fen = 0, fst = 0, src = 1, pt = 0, pa = 0, ct = 0, ca = 0;
  int          nclk = 0, rt = 0, rm = 0, nrec = 0, lrec = 0;
  int          tl[8], alv[8], am[8], dt[8], da[8], cnt[5];
  int          evq[$];

  // 10 MHz reference clock
  always #50 clk = ~clk;

  pfp_stage #(.CYCLE_CLKS(CYC), .MS_CLKS(MSC)) uut (
    .REF_CLK(clk), .RESETN(rstn), .GROUP_SEL(grp), .PF_A(pfa), .PF_B(pfb), .BLOCK_IN(blk),
    .REG_ADDR(addr), .REG_WDATA(wd), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
    .ALARM_START(o_ast), .ALARM(o_alm), .START(o_st), .TRIP(o_tr), .BLOCKED(o_bl),
    .EVT_VALID(ev), .EVT_SIG(esig), .EVT_ON(eon), .EVT_TIME(etime));
  pfp_meas_model #(.CYCLE_CLKS(CYC)) u_meas (.clk(clk), .rst_n(rstn), .pf_a_req(ra), .pf_b_req(rb),
    .blk_req(rblk), .pf_a(pfa), .pf_b(pfb), .blk(blk));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [9:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [9:0] a, input logic [31:0] exp, input string nm);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    chk(nm, rdata, exp);
  endtask
  // park six clocks past a tick so writes never race the sampling edge
  task automatic wt(input int n);
    repeat (n) begin
      do @(posedge clk); while (cyc != 5);
    end
  endtask
  function automatic int lvl(input int v);
    return (v < 5) ? 5 : (v > 99) ? 99 : v;
  endfunction
  task automatic sg(input int g, input int m, input int a, input int t, input int d);
    wr_reg(10'(256 + 16 * g), 32'((m << 16) | (a << 8) | t));
    wr_reg(10'(260 + 16 * g), 32'(d));
    wr_reg(10'(264 + 16 * g), 32'(d / 2));
    am[g] = m;
    alv[g] = lvl(a);
    tl[g] = lvl(t);
    dt[g] = d;
    da[g] = d / 2;
  endtask
  function automatic logic [31:0] stat();
    logic [2:0] c;
    c = mo[3] ? 3'h2 : mo[1] ? 3'h5 : mo[2] ? 3'h1 : mo[0] ? 3'h4 : mo[4] ? 3'h3 : 3'h0;
    return {19'h0, mo, 5'h0, c};
  endfunction
  // one tick of the reference stage, on the same inputs the design samples
  task automatic step();
    int pf;
    int g;
    logic b;
    logic [4:0] n;
    pf = (src == 2) ? int'(pfb) : int'(pfa);
    g = int'(grp);
    b = blk || node == 2 || node == 4;
    pt = pt ? int'(pf * 100 <= tl[g] * 1030) : int'(pf < tl[g] * 10);
    pa = am[g] * (pa ? int'(pf * 100 <= alv[g] * 1030) : int'(pf < alv[g] * 10));
    // a stage switched off forgets its pick-up and starts afresh when back on
    if (node == 5) begin
      pt = 0;
      pa = 0;
    end
    n = 5'h00;
    rm = 0;
    rt = 0;
    if (b) begin
      n[4] = (pt | pa) != 0;
      ct = 0;
      ca = 0;
    end else begin
      n[0] = pa != 0;
      n[1] = pa != 0 && ca >= da[g];
      n[2] = pt != 0;
      n[3] = pt != 0 && ct >= dt[g];
      if (pa != 0 && ca < da[g]) rm = da[g] - ca;
      if (pt != 0) rt = dt[g] - ct;
      ca = pa ? ca + 1 : 0;
      ct = pt ? ct + 1 : 0;
    end
    if (node == 2 || node == 4) n = 5'h10;
    if (node == 5) n = 5'h00;
    if (fen != 0) n = FRC[fst];
    if ((n[4:2] & ~mo[4:2]) != 3'h0) begin
      nrec++;
      lrec = nclk / MSC;
    end
    for (int i = 0; i < 5; i++) begin
      if (n[i] != mo[i]) evq.push_back(nclk / MSC * 16 + 2 * i + n[i]);
      if (n[i] && !mo[i]) cnt[i]++;
    end
    mo = n;
  endtask
  task automatic end_sim();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // tick phase, model step and output and event comparison
  always @(posedge clk) begin
    if (!rstn) cyc <= 0;
    else cyc <= (cyc == CYC - 1) ? 0 : cyc + 1;
    nclk <= rstn ? nclk + 1 : 0; // edges since reset, the base of the millisecond stamp
    if (rstn && cyc == CYC - 1) step();
    if (rstn && cyc == 2) chk("outputs", {27'h0, o_bl, o_tr, o_st, o_alm, o_ast}, {27'h0, mo});
    if (rstn && ev)
      chk("event", {etime[27:0], esig, eon}, evq.size() ? 32'(evq.pop_front()) : 32'hffffffff);
  end

  // the run takes about 200 ticks; 600 ticks means a hang
  initial begin
    #1200000;
    n_mismatch++;
    $display("watchdog expired");
    end_sim();
  end

  initial begin
    for (int g = 0; g < 8; g++) begin
      tl[g] = 80;
      alv[g] = 90;
      am[g] = 1;
      dt[g] = 0;
      da[g] = 0;
    end
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    rd_chk(10'h000, 32'h00000101, "ctrl");
    for (int g = 0; g < 8; g++) rd_chk(10'(256 + 16 * g), 32'h00015a50, "group");
    rd_chk(10'h3fc, 32'h0, "unmapped");
    sg(7, 0, 120, 3, 3);
    rd_chk(10'h170, 32'h00006305, "clamped");
    sg(1, 1, 95, 60, 2);
    sg(2, 0, 90, 85, 4);
    $display("test defaults done");
    ra <= 10'h2bc;
    wt(3);
    ra <= 10'h2d0;
    wt(5);
    rd_chk(10'h014, 32'h50, "alarm ratio");
    rd_chk(10'h018, 32'h5a, "trip ratio");
    rd_chk(10'h01c, 32'h0, "expected time");
    rd_chk(10'h020, 32'h2d0, "prefault");
    ra <= 10'h338;
    wt(2);
    ra <= 10'h339;
    wt(2);
    rb <= 10'h2bc;
    wr_reg(10'h000, 32'h201);
    src = 2;
    wt(2);
    wr_reg(10'h000, 32'h101);
    src = 1;
    wt(2);
    $display("test pickup done");
    ra <= 10'h2bc;
    for (int m = 1; m < 6; m++) begin
      wr_reg(10'h000, 32'(256 + m));
      node = m;
      wt(2);
      rd_chk(10'h004, stat(), "mode status");
    end
    wr_reg(10'h000, 32'h107);
    rd_chk(10'h000, 32'h105, "bad mode");
    for (int f = 0; f < 6; f++) begin
      wr_reg(10'h000, 32'(265 + 16 * f));
      node = 1;
      fen = 1;
      fst = f;
      wt(2);
      rd_chk(10'h004, stat(), "forced status");
    end
    wr_reg(10'h000, 32'h101);
    fen = 0;
    wt(1);
    $display("test modes done");
    // random groups, levels and blocking; the model tracks every tick
    for (int i = 0; i < 60; i++) begin
      grp <= 3'($random(seed));
      ra <= 10'(600 + {$random(seed)} % 401);
      rb <= 10'(600 + {$random(seed)} % 401);
      rblk <= ({$random(seed)} % 5) == 0;
      wt(1 + {$random(seed)} % 3);
      rd_chk(10'h00c, 32'(rm), "time to alarm");
      rd_chk(10'h010, 32'(rt), "time to trip");
    end
    $display("test random done");
    ra <= 10'h3e8;
    rb <= 10'h3e8;
    rblk <= 1'b0;
    wt(3);
    for (int i = 0; i < 5; i++) rd_chk(10'(64 + 4 * i), 32'(cnt[i]), "counter");
    wr_reg(10'h008, 32'h1f);
    for (int i = 0; i < 5; i++) rd_chk(10'(64 + 4 * i), 32'h0, "cleared");
    rd_chk(10'h024, 32'((nrec % 12) * 16), "record pointer");
    wr_reg(10'h024, 32'((nrec + 11) % 12));
    rd_chk(10'h028, 32'(lrec), "record time");
    chk("events left", 32'(evq.size()), 32'h0);
    $display("test counters done");
    end_sim();
  end
endmodule // pfp_stage_tb_top
